// file: logic/vbi_data_inserter.sv
`timescale 1ns/1ps
`include "vbi_data_inserter_cfg.svh"
// What this block does
// - Captions on odd line 21, even 284
// - Caption line opens with seven-cycle run-in
// - Two blank bit periods, then start one
// - Sixteen bits: two bytes, odd parity each
// - Even field line 284 uses extended bytes
// - Caption lines ignore incoming pixels entirely
// - Copy data on odd 20, even 283
// - Per-parity enables gate copy data
// - Copy data only in NTSC mode
// - Reference pulse then twenty copy bits
// - Copy bit sources: reg0 nibble, reg1, reg2
// - Auto CRC replaces top six bits
// - CRC x^6+x+1, preset all ones
// - Without auto CRC send registers verbatim
// - Widescreen data on line 23
// - Widescreen only in PAL mode
// - Run-in, start code, fourteen data bits
// - Widescreen bits from reg2 and reg1
// - Widescreen enable gates line 23 insertion
// - Line 23 video resumes at 42.5 us
// - Shared bits: widescreen PAL, copy NTSC
module vbi_data_inserter #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Timing generator
  input wire logic line_start,
  input wire vbi_pkg::line_t line_number,
  input wire logic field_odd,
  // Configuration
  input wire logic ntsc_mode,
  input wire vbi_pkg::byte_t cc_byte0,
  input wire vbi_pkg::byte_t cc_byte1,
  input wire vbi_pkg::byte_t cc_ext_byte0,
  input wire vbi_pkg::byte_t cc_ext_byte1,
  input wire logic crc_auto_enable,
  input wire logic copy_info_odd_field_enable,
  input wire logic copy_info_even_field_enable,
  input wire logic widescreen_enable,
  input wire logic [3:0] copy_bits_reg0,
  input wire vbi_pkg::byte_t shared_bits_reg1,
  input wire vbi_pkg::byte_t shared_bits_reg2,
  // Pixel input
  input wire vbi_pkg::byte_t pix_in_data,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  // Video output
  output vbi_pkg::byte_t video_out_data,
  output logic video_out_valid,
  input wire logic video_out_ready,
  // Status
  output logic substituting,
  output vbi_pkg::service_e active_service
);
  import vbi_pkg::*;

  localparam logic [10:0] CC_BIT_M1 = 11'(`CC_BIT_CYC - 1);
  localparam logic [10:0] CC_LEAD_M1 = 11'(`CC_START_CYC - 1);
  localparam logic [10:0] CGMS_BIT_M1 = 11'(`CGMS_BIT_CYC - 1);
  localparam logic [10:0] CGMS_LEAD_M1 = 11'(`CGMS_START_CYC - 1);
  localparam logic [10:0] WSS_BIT_M1 = 11'(`WSS_BIT_CYC - 1);
  localparam logic [10:0] WSS_LEAD_M1 = 11'(`WSS_START_CYC - 1);
  localparam logic [10:0] WSS_VIDEO_M1 = 11'(`WSS_VIDEO_CYC - 1);
  localparam logic [2:0] RUNIN_LAST = 3'(`CC_RUNIN_CYCLES - 1);
  localparam logic [6:0] CC_LAST = 7'(`CC_FRAME_BITS - 1);
  localparam logic [6:0] CGMS_LAST = 7'(`CGMS_FRAME_BITS - 1);
  localparam logic [6:0] WSS_LAST =
    7'(`WSS_RUNIN_LEN + `WSS_START_LEN + `WSS_DATA_BITS - 1);

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("vbi_data_inserter: FIFO_DEPTH must be at least 2");
  end

  // Seven data bits with odd parity in bit 7
  function automatic byte_t cc_fmt(input byte_t b);
    return {~^b[6:0], b[6:0]};
  endfunction : cc_fmt

  function automatic logic [5:0] crc6(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = `CRC_PRESET;
    for (int i = 0; i < 14; i++) begin
      fb = d[i] ^ c[5];
      c = {c[4:0], 1'b0} ^ ({6{fb}} & `CRC_POLY);
    end
    return c;
  endfunction : crc6

  // Four-step sine approximation over one bit period
  function automatic byte_t runin_level(input logic [10:0] c, input logic [10:0] p);
    if (c < (p >> 2)) begin
      return `LEVEL_MID;
    end else if (c < (p >> 1)) begin
      return `LEVEL_HIGH;
    end else if (c < p - (p >> 2)) begin
      return `LEVEL_MID;
    end else begin
      return `LEVEL_BLANK;
    end
  endfunction : runin_level

  // Line decode
  logic is_cc, is_cgms, is_wss;
  byte_t cc_lo, cc_hi;
  logic [19:0] copy_word;
  logic [13:0] wide_word;

  assign is_cc = ntsc_mode && (field_odd ? line_number == `CC_LINE_ODD
                                         : line_number == `CC_LINE_EVEN);
  assign is_cgms = ntsc_mode && (field_odd
    ? line_number == `CGMS_LINE_ODD && copy_info_odd_field_enable
    : line_number == `CGMS_LINE_EVEN && copy_info_even_field_enable);
  assign is_wss = !ntsc_mode && widescreen_enable
    && line_number == `WSS_LINE;
  // Bytes are sampled at the line's start; host must have loaded them earlier
  assign cc_lo = cc_fmt(field_odd ? cc_byte0 : cc_ext_byte0);
  assign cc_hi = cc_fmt(field_odd ? cc_byte1 : cc_ext_byte1);
  assign wide_word = {shared_bits_reg1[5:0], shared_bits_reg2};

  always_comb begin
    copy_word = {copy_bits_reg0, shared_bits_reg1, shared_bits_reg2};
    if (crc_auto_enable) begin
      copy_word[19:14] = crc6(copy_word[13:0]);
    end
  end

  // Waveform generator
  gen_state_e state_q, state_d;
  service_e svc_q, svc_d;
  seq_t seq_q, seq_d;
  logic [6:0] idx_q, idx_d, last_q, last_d;
  logic [10:0] cyc_q, cyc_d, bit_m1_q, bit_m1_d, lead_m1_q, lead_m1_d;
  logic [10:0] line_cyc_q, line_cyc_d;
  logic [2:0] runs_q, runs_d;
  logic hold_q, hold_d;
  byte_t level_q, level_d;
  logic bit_end;

  assign bit_end = cyc_q == bit_m1_q;

  always_comb begin
    state_d = state_q;
    svc_d = svc_q;
    seq_d = seq_q;
    idx_d = idx_q;
    last_d = last_q;
    cyc_d = cyc_q + 11'h001;
    bit_m1_d = bit_m1_q;
    lead_m1_d = lead_m1_q;
    runs_d = runs_q;
    hold_d = hold_q;
    line_cyc_d = (line_cyc_q == '1) ? line_cyc_q : line_cyc_q + 11'h001;
    if (svc_q == SVC_WSS && line_cyc_q == WSS_VIDEO_M1) begin
      hold_d = 1'b0;
    end
    unique case (state_q)
      GEN_IDLE: begin
        cyc_d = '0;
      end
      GEN_LEAD: begin
        if (cyc_q == lead_m1_q) begin
          cyc_d = '0;
          state_d = (svc_q == SVC_CC) ? GEN_RUNIN : GEN_SHIFT;
        end
      end
      GEN_RUNIN: begin
        if (bit_end) begin
          cyc_d = '0;
          runs_d = runs_q + 3'h1;
          if (runs_q == RUNIN_LAST) begin
            state_d = GEN_SHIFT;
          end
        end
      end
      GEN_SHIFT: begin
        if (bit_end) begin
          cyc_d = '0;
          seq_d = seq_q >> 1;
          idx_d = idx_q + 7'h01;
          if (idx_q == last_q) begin
            state_d = GEN_IDLE;
            if (svc_q == SVC_CGMS) begin
              hold_d = 1'b0;
            end
          end
        end
      end
    endcase
    // A new line restarts everything, even a frame still in flight
    if (line_start) begin
      line_cyc_d = '0;
      cyc_d = '0;
      runs_d = '0;
      idx_d = '0;
      hold_d = is_cc || is_cgms || is_wss;
      state_d = (is_cc || is_cgms || is_wss) ? GEN_LEAD : GEN_IDLE;
      svc_d = SVC_NONE;
      if (is_cc) begin
        svc_d = SVC_CC;
        seq_d = seq_t'({cc_hi, cc_lo, 1'b1, 2'b00});
        last_d = CC_LAST;
        bit_m1_d = CC_BIT_M1;
        lead_m1_d = CC_LEAD_M1;
      end else if (is_cgms) begin
        svc_d = SVC_CGMS;
        seq_d = seq_t'({copy_word, 1'b1});
        last_d = CGMS_LAST;
        bit_m1_d = CGMS_BIT_M1;
        lead_m1_d = CGMS_LEAD_M1;
      end else if (is_wss) begin
        svc_d = SVC_WSS;
        seq_d = seq_t'({wide_word, `WSS_START_CODE, `WSS_RUNIN});
        last_d = WSS_LAST;
        bit_m1_d = WSS_BIT_M1;
        lead_m1_d = WSS_LEAD_M1;
      end
    end
    unique case (state_q)
      GEN_RUNIN: level_d = runin_level(cyc_q, bit_m1_q + 11'h001);
      GEN_SHIFT: level_d = seq_q[0] ? `LEVEL_HIGH : `LEVEL_BLANK;
      GEN_IDLE, GEN_LEAD: level_d = `LEVEL_BLANK;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= GEN_IDLE;
      svc_q <= SVC_NONE;
      seq_q <= '0;
      idx_q <= '0;
      last_q <= '0;
      cyc_q <= '0;
      bit_m1_q <= '0;
      lead_m1_q <= '0;
      line_cyc_q <= '0;
      runs_q <= '0;
      hold_q <= 1'b0;
      level_q <= `LEVEL_BLANK;
    end else begin
      state_q <= state_d;
      svc_q <= svc_d;
      seq_q <= seq_d;
      idx_q <= idx_d;
      last_q <= last_d;
      cyc_q <= cyc_d;
      bit_m1_q <= bit_m1_d;
      lead_m1_q <= lead_m1_d;
      line_cyc_q <= line_cyc_d;
      runs_q <= runs_d;
      hold_q <= hold_d;
      level_q <= level_d;
    end
  end

  // Pixel path
  byte_t fifo_data;
  logic fifo_valid, drain_ok, take;
  byte_t vout_data_q, vout_data_d;
  logic vout_valid_q, vout_valid_d;

  vbi_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(pix_in_data),
    .in_valid(pix_in_valid),
    .in_ready(pix_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(drain_ok)
  );

  assign drain_ok = !vout_valid_q || video_out_ready;
  assign take = fifo_valid && drain_ok;

  always_comb begin
    vout_valid_d = take || (vout_valid_q && !video_out_ready);
    vout_data_d = vout_data_q;
    if (take) begin
      vout_data_d = hold_q ? level_q : fifo_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vout_data_q <= `LEVEL_BLANK;
      vout_valid_q <= 1'b0;
    end else begin
      vout_data_q <= vout_data_d;
      vout_valid_q <= vout_valid_d;
    end
  end

  assign video_out_data = vout_data_q;
  assign video_out_valid = vout_valid_q;
  assign substituting = hold_q;
  assign active_service = svc_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_odd_cc_line;
    line_start && ntsc_mode && field_odd && line_number == `CC_LINE_ODD;
  endsequence
  sequence s_runin_end;
    state_q == GEN_RUNIN && bit_end && runs_q == RUNIN_LAST;
  endsequence

  a_cc_odd_line: assert property (s_odd_cc_line |=>
    svc_q == SVC_CC && state_q == GEN_LEAD && hold_q)
    else $error("caption line not started on odd line 21");
  a_runin_count: assert property (s_runin_end |=>
    state_q == GEN_SHIFT && cyc_q == '0 && idx_q == '0)
    else $error("run-in did not end after seven cycles");
  a_runin_only_end: assert property (
    $past(state_q) == GEN_RUNIN && state_q == GEN_SHIFT |-> $past(runs_q) == RUNIN_LAST)
    else $error("run-in left early");
  a_cc_gap_start: assert property (
    state_q == GEN_LEAD && svc_q == SVC_CC |-> seq_q[2:0] == 3'b100 && last_q == CC_LAST)
    else $error("caption gap or start bit wrong");
  a_cc_parity_odd: assert property (
    state_q == GEN_LEAD && svc_q == SVC_CC |-> ^seq_q[10:3] && ^seq_q[18:11])
    else $error("caption byte parity not odd");
  a_cc_ext_bytes: assert property (
    line_start && ntsc_mode && !field_odd && line_number == `CC_LINE_EVEN
    |=> seq_q[9:3] == $past(cc_ext_byte0[6:0]) && seq_q[17:11] == $past(cc_ext_byte1[6:0]))
    else $error("extended caption bytes not used on line 284");
  a_cc_pixels_ignored: assert property (
    svc_q == SVC_CC && hold_q && take |=> video_out_data == $past(level_q))
    else $error("pixel passed on a caption line");
  a_copy_field_gate: assert property (
    line_start && ntsc_mode && field_odd && line_number == `CGMS_LINE_ODD
    && !copy_info_odd_field_enable |=> svc_q == SVC_NONE && !hold_q)
    else $error("copy data sent with odd enable clear");
  a_copy_ntsc_only: assert property (line_start && !ntsc_mode |=>
    svc_q != SVC_CGMS && svc_q != SVC_CC)
    else $error("NTSC service started in PAL");
  a_copy_ref_pulse: assert property (
    state_q == GEN_LEAD && svc_q == SVC_CGMS |-> seq_q[0] && last_q == CGMS_LAST)
    else $error("copy frame lacks reference pulse");
  a_copy_crc: assert property (
    line_start && is_cgms && crc_auto_enable |=> seq_q[20:15] == crc6(seq_q[14:1]))
    else $error("auto CRC bits wrong");
  a_wide_pal_only: assert property (line_start && ntsc_mode |=>
    svc_q != SVC_WSS)
    else $error("widescreen started in NTSC");
  a_wide_video_resume: assert property (
    svc_q == SVC_WSS && line_cyc_q == WSS_VIDEO_M1 && !line_start |=> !hold_q)
    else $error("line 23 video not resumed at 42.5 us");
endmodule : vbi_data_inserter

// file: shared/vbi_data_inserter_cfg.svh
`ifndef VBI_DATA_INSERTER_CFG_SVH
`define VBI_DATA_INSERTER_CFG_SVH

// Clock period in ns (25 MHz)
`define CLK_NS 40

// Service lines, frame numbering
`define CC_LINE_ODD 10'h015
`define CC_LINE_EVEN 10'h11c
`define CGMS_LINE_ODD 10'h014
`define CGMS_LINE_EVEN 10'h11b
`define WSS_LINE 10'h017

// Element periods and start delays from the sync edge, in ns
`define CC_BIT_NS 1986
`define CC_START_NS 10500
`define CGMS_BIT_NS 2234
`define CGMS_START_NS 11200
`define WSS_BIT_NS 200
`define WSS_START_NS 11000
`define WSS_VIDEO_NS 42500

// Periods round to nearest, delays round up
`define CC_BIT_CYC ((`CC_BIT_NS + `CLK_NS / 2) / `CLK_NS)
`define CC_START_CYC ((`CC_START_NS + `CLK_NS - 1) / `CLK_NS)
`define CGMS_BIT_CYC ((`CGMS_BIT_NS + `CLK_NS / 2) / `CLK_NS)
`define CGMS_START_CYC ((`CGMS_START_NS + `CLK_NS - 1) / `CLK_NS)
`define WSS_BIT_CYC ((`WSS_BIT_NS + `CLK_NS / 2) / `CLK_NS)
`define WSS_START_CYC ((`WSS_START_NS + `CLK_NS - 1) / `CLK_NS)
`define WSS_VIDEO_CYC ((`WSS_VIDEO_NS + `CLK_NS - 1) / `CLK_NS)

// Caption run-in cycles and frame lengths in elements
`define CC_RUNIN_CYCLES 7
`define CC_FRAME_BITS 19
`define CGMS_FRAME_BITS 21
`define WSS_DATA_BITS 14

// CRC: x^6 + x + 1, preset all ones
`define CRC_PRESET 6'h3f
`define CRC_POLY 6'h03

// Widescreen run-in and start code, sent LSB first
`define WSS_RUNIN 29'h0aaaaaaa
`define WSS_RUNIN_LEN 29
`define WSS_START_CODE 24'h0f0f0f
`define WSS_START_LEN 24

// Output levels and their reset value
`define LEVEL_BLANK 8'h10
`define LEVEL_MID 8'h47
`define LEVEL_HIGH 8'h7e

`endif

// file: shared/vbi_pkg.sv
package vbi_pkg;
  typedef logic [9:0] line_t;
  typedef logic [7:0] byte_t;
  typedef logic [71:0] seq_t;
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_LEAD = 2'b01,
    GEN_RUNIN = 2'b10,
    GEN_SHIFT = 2'b11
  } gen_state_e;
  typedef enum logic [1:0] {
    SVC_NONE = 2'b00,
    SVC_CC = 2'b01,
    SVC_CGMS = 2'b10,
    SVC_WSS = 2'b11
  } service_e;
endpackage : vbi_pkg

// file: logic/vbi_fifo.sv
`timescale 1ns/1ps
module vbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("vbi_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic ready_q, ready_d;
  logic push, pop;

  assign push = in_valid && ready_q;
  assign pop = out_valid && out_ready;
  assign in_ready = ready_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
    cnt_d = cnt_q + CW'(push) - CW'(pop);
    // Ready is registered so the fill side sees a flop
    ready_d = cnt_d != CW'(DEPTH);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q <= '{default: '0};
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
    end
  end
endmodule : vbi_fifo

// file: tb/vbi_rx_model.sv
`timescale 1ns/1ps
module vbi_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Video stream from the inserter
  input wire vbi_pkg::byte_t video_out_data,
  input wire logic video_out_valid,
  output logic video_out_ready,
  // Pacing: 0 prompt, 1 slow and uneven, 2 stalled
  input wire logic [1:0] pace,
  // Last sample digitised
  output vbi_pkg::byte_t last_sample
);
  import vbi_pkg::*;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      video_out_ready <= 1'b0;
      last_sample <= 8'h00;
    end else begin
      if (video_out_valid && video_out_ready) begin
        last_sample <= video_out_data;
      end
      case (pace)
        2'h0: video_out_ready <= 1'b1;
        2'h1: video_out_ready <= ($urandom % 3) != 0;
        default: video_out_ready <= 1'b0;
      endcase
    end
  end
endmodule : vbi_rx_model

// file: tb/vbi_data_inserter_tb.sv
`timescale 1ns/1ps
`include "vbi_data_inserter_cfg.svh"
module vbi_data_inserter_tb;
  import vbi_pkg::*;
  typedef struct {int at; byte_t v;} note_s;
  logic clk, reset_n, line_start, field_odd, ntsc_mode, crc_auto_enable, widescreen_enable;
  logic copy_info_odd_field_enable, copy_info_even_field_enable, pix_in_valid, pix_in_ready;
  logic video_out_valid, video_out_ready, substituting;
  line_t line_number;
  byte_t cc_byte0, cc_byte1, cc_ext_byte0, cc_ext_byte1, shared_bits_reg1, shared_bits_reg2;
  byte_t pix_in_data, video_out_data, r1, r2, b0, b1, e0, e1;
  logic [3:0] copy_bits_reg0, r0;
  logic [19:0] w;
  service_e active_service;
  logic [1:0] pace;
  int cyc, miscompares, checks_done, feed, pix_check, i;
  note_s wq[$];
  byte_t pq[$];

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  vbi_data_inserter uut (.clk(clk), .reset_n(reset_n), .line_start(line_start),
    .line_number(line_number), .field_odd(field_odd), .ntsc_mode(ntsc_mode),
    .cc_byte0(cc_byte0), .cc_byte1(cc_byte1), .cc_ext_byte0(cc_ext_byte0),
    .cc_ext_byte1(cc_ext_byte1), .crc_auto_enable(crc_auto_enable),
    .copy_info_odd_field_enable(copy_info_odd_field_enable),
    .copy_info_even_field_enable(copy_info_even_field_enable),
    .widescreen_enable(widescreen_enable), .copy_bits_reg0(copy_bits_reg0),
    .shared_bits_reg1(shared_bits_reg1), .shared_bits_reg2(shared_bits_reg2),
    .pix_in_data(pix_in_data), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
    .video_out_data(video_out_data), .video_out_valid(video_out_valid),
    .video_out_ready(video_out_ready), .substituting(substituting),
    .active_service(active_service));

  vbi_rx_model rx (.clk(clk), .reset_n(reset_n), .video_out_data(video_out_data),
    .video_out_valid(video_out_valid), .video_out_ready(video_out_ready), .pace(pace),
    .last_sample());

  task automatic cmp_byte(input string what, input byte_t exp, input byte_t got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_svc(input string what, input service_e exp, input service_e got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_svc

  task automatic give_verdict();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  function automatic byte_t par(input byte_t b);
    return {~^b[6:0], b[6:0]};
  endfunction : par

  // Serial over C0..C13, result lands in C14..C19
  function automatic logic [5:0] crc6(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = 6'h3f;
    for (int k = 0; k < 14; k++) begin
      fb = d[k] ^ c[5];
      c = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
    end
    return c;
  endfunction : crc6

  task automatic note(input int at, input byte_t v);
    note_s n;
    n.at = at;
    n.v = v;
    wq.push_back(n);
  endtask : note

  always @(posedge clk) cyc <= cyc + 1;

  // Pixel source: holds a word until it is taken
  always @(posedge clk) begin
    if (pix_in_valid && pix_in_ready && pix_check != 0) begin
      pq.push_back(pix_in_data);
    end
    if (!pix_in_valid || pix_in_ready) begin
      pix_in_valid <= (feed == 1) || (feed == 2 && ($urandom % 4) != 0);
      pix_in_data <= byte_t'($urandom);
    end
  end

  // Output watcher: pass-through words and timed waveform levels
  always @(posedge clk) begin
    if (video_out_valid && video_out_ready && pix_check != 0) begin
      if (pq.size() == 0) begin
        cmp_bit("pixel queue nonempty", 1'b1, 1'b0);
      end else begin
        cmp_byte("video_out_data", pq.pop_front(), video_out_data);
      end
    end
    if (wq.size() != 0 && wq[0].at == cyc) begin
      cmp_bit("video_out_valid", 1'b1, video_out_valid);
      cmp_byte("video_out_data level", wq[0].v, video_out_data);
      void'(wq.pop_front());
    end
  end

  task automatic cfg(input logic ntsc, input logic crc, input logic oe, input logic ee,
      input logic we);
    @(posedge clk);
    ntsc_mode <= ntsc;
    crc_auto_enable <= crc;
    copy_info_odd_field_enable <= oe;
    copy_info_even_field_enable <= ee;
    widescreen_enable <= we;
    copy_bits_reg0 <= r0;
    shared_bits_reg1 <= r1;
    shared_bits_reg2 <= r2;
    cc_byte0 <= b0;
    cc_byte1 <= b1;
    cc_ext_byte0 <= e0;
    cc_ext_byte1 <= e1;
  endtask : cfg

  // Sample point: element start past the output pipeline, then mid-element
  task automatic run_line(input line_t ln, input logic odd, input service_e svc,
      input int lead, input int per, input int n, input seq_t bits, input int hold);
    int t0;
    @(posedge clk);
    line_start <= 1'b1;
    line_number <= ln;
    field_odd <= odd;
    t0 = cyc;
    if (svc == SVC_CC) begin
      for (int k = 0; k < 7; k++) begin
        note(t0 + lead + 5 + per * k + 19, 8'h7e);
        note(t0 + lead + 5 + per * k + 44, 8'h10);
      end
      t0 = t0 + 7 * per;
    end
    for (int k = 0; k < n; k++) begin
      note(t0 + lead + 5 + per * k + per / 2, bits[k] ? 8'h7e : 8'h10);
    end
    @(posedge clk);
    line_start <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    cmp_svc("active_service", svc, active_service);
    cmp_bit("substituting", svc != SVC_NONE, substituting);
    repeat (hold) @(posedge clk);
  endtask : run_line

  initial begin
    reset_n = 1'b0;
    {line_start, field_odd, ntsc_mode, crc_auto_enable, widescreen_enable} = '0;
    {copy_info_odd_field_enable, copy_info_even_field_enable, pix_in_valid} = '0;
    {cc_byte0, cc_byte1, cc_ext_byte0, cc_ext_byte1, shared_bits_reg1} = '0;
    {shared_bits_reg2, pix_in_data, copy_bits_reg0, line_number, pace} = '0;
    {r0, r1, r2} = '0;
    void'($urandom(70));
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_bit("pix_in_ready", 1'b0, pix_in_ready);
    cmp_bit("video_out_valid", 1'b0, video_out_valid);
    cmp_byte("video_out_data", 8'h10, video_out_data);
    cmp_svc("active_service", SVC_NONE, active_service);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    pix_check = 1;
    feed = 2;
    pace = 2'h1;
    run_line(10'h01e, 1'b1, SVC_NONE, 0, 0, 0, '0, 200);
    @(negedge clk);
    pace = 2'h2;
    feed = 1;
    for (i = 0; i < 40 && pix_in_ready; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    cmp_bit("pix_in_ready", 1'b0, pix_in_ready);
    cmp_byte("words held", 8'h05, byte_t'(pq.size()));
    feed = 0;
    pace = 2'h1;
    for (i = 0; i < 300 && pq.size() != 0; i++) @(negedge clk);
    if (i == 300) begin
      miscompares++;
      give_verdict();
    end
    pix_check = 0;
    feed = 1;
    pace = 2'h0;
    // Captions, the second odd line carries the null pattern
    for (int k = 0; k < 3; k++) begin
      b0 = (k == 1) ? 8'h00 : byte_t'($urandom);
      b1 = (k == 1) ? 8'h00 : byte_t'($urandom);
      e0 = byte_t'($urandom);
      e1 = byte_t'($urandom);
      cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      if (k < 2) begin
        run_line(10'h015, 1'b1, SVC_CC, 263, 50, 19, {par(b1), par(b0), 3'b100}, 1600);
      end else begin
        run_line(10'h11c, 1'b0, SVC_CC, 263, 50, 19, {par(e1), par(e0), 3'b100}, 1600);
      end
    end
    // Copy data: auto CRC, verbatim, parity gating, PAL
    for (int k = 0; k < 4; k++) begin
      r0 = 4'($urandom);
      r1 = byte_t'($urandom);
      r2 = byte_t'($urandom);
      w = {r0, r1, r2};
      if (k == 0) w[19:14] = crc6(w[13:0]);
      cfg(k != 3, k == 0, k == 0 || k == 3, k == 1 || k == 2, 1'b0);
      run_line((k == 1) ? 10'h11b : 10'h014, k != 1, (k < 2) ? SVC_CGMS : SVC_NONE, 280, 56,
        (k < 2) ? 21 : 0, {w, 1'b1}, (k < 2) ? 1500 : 20);
    end
    // Widescreen: enabled PAL, then NTSC, then disabled
    for (int k = 0; k < 3; k++) begin
      r0 = 4'($urandom);
      r1 = byte_t'($urandom);
      r2 = byte_t'($urandom);
      cfg(k == 1, 1'b0, 1'b1, 1'b1, k != 2);
      run_line(10'h017, 1'b0, (k == 0) ? SVC_WSS : SVC_NONE, 275, 5, (k == 0) ? 67 : 0,
        {r1[5:0], r2, `WSS_START_CODE, `WSS_RUNIN}, 0);
      if (k == 0) begin
        repeat (1000) @(negedge clk);
        cmp_bit("substituting", 1'b1, substituting);
        repeat (70) @(negedge clk);
        cmp_bit("substituting", 1'b0, substituting);
      end
      repeat (20) @(posedge clk);
    end
    @(negedge clk);
    cmp_bit("notes pending", 1'b1, wq.size() == 0);
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule : vbi_data_inserter_tb
